// >>> core/pao_core.sv
// Purpose: numerically controlled oscillator with 20-bit phase accumulator
// Assumes: clock sources are synchronous levels sampled on mclk_in
// Notes: a synth clock edge is a rising edge of the selected source level
`timescale 1ns/100ps

module pao_core
  import pao_pkg::*;
#(
  parameter int ACC_W = `PAO_ACC_W,
  parameter int WSEL_W = `PAO_WSEL_W,
  parameter int SRC_N = `PAO_CKS_SRC_N
)
(
  input wire logic mclk_in,                    // module clock, 40 MHz
  input wire logic rst_n_in,                   // sync reset, active low
  input wire logic ce_in,                      // clock enable, freezes all state
  input wire logic enable_in,                  // module enable
  input wire logic pulse_mode_select_in,       // 1 pulse mode, 0 toggle mode
  input wire logic output_invert_in,           // output polarity
  input wire logic [WSEL_W-1:0] pulse_width_select_in, // pulse width code
  input wire logic [`PAO_CKS_W-1:0] clock_source_select_in, // source code
  input wire logic [SRC_N-1:0] clk_src_in,     // source levels, index = code
  input wire logic [7:0] wr_data_in,           // byte write data
  input wire logic increment_low_byte_we_in,   // write strobes
  input wire logic increment_high_byte_we_in,  // increment high
  input wire logic increment_upper_byte_we_in, // increment upper
  input wire logic accumulator_low_byte_we_in, // accumulator low
  input wire logic accumulator_high_byte_we_in, // accumulator high
  input wire logic accumulator_upper_byte_we_in, // accumulator upper
  output logic [ACC_W-1:0] increment_out,      // increment holding value
  output logic [ACC_W-1:0] accumulator_out,    // accumulator value
  output logic accumulator_carry_out,          // raw overflow, one-cycle pulse
  output logic overflow_flag_out,              // overflow request, one-cycle pulse
  output logic synth_out,                      // final output
  output logic out_status_out                  // output status mirror
);

  // =====================================================
  // state
  logic [ACC_W-1:0] inc_hold_r;
  logic [ACC_W-1:0] inc_hold_nxt;
  logic [ACC_W-1:0] inc_buf_r;
  logic [ACC_W-1:0] inc_buf_nxt;
  logic [ACC_W-1:0] acc_r;
  logic [ACC_W-1:0] acc_nxt;
  logic [1:0] ld_cnt_r;
  logic [1:0] ld_cnt_nxt;
  pao_ld_state_t ld_st_r;
  pao_ld_state_t ld_st_nxt;
  logic src_d_r;
  logic src_d_nxt;
  logic carry_r;
  logic carry_nxt;
  logic tog_r;
  logic tog_nxt;
  logic out_r;
  logic out_nxt;
  logic flag_r;
  logic flag_nxt;
  logic pin_r;
  logic pin_nxt;

  logic src_lvl;
  logic synth_edge;
  logic [ACC_W:0] sum;
  logic pulse_act;

  // =====================================================
  // clock source select
  // source mux
  assign src_lvl = (32'(clock_source_select_in) < SRC_N) ?
                   clk_src_in[clock_source_select_in] : 1'b0;
  assign synth_edge = enable_in & src_lvl & ~src_d_r;

  // =====================================================
  // adder
  // combinational adder
  assign sum = {1'b0, acc_r} + {1'b0, inc_buf_r};

  always_comb
  begin
    inc_hold_nxt = inc_hold_r;
    if (increment_low_byte_we_in)
      inc_hold_nxt[7:0] = wr_data_in;
    if (increment_high_byte_we_in)
      inc_hold_nxt[15:8] = wr_data_in;
    if (increment_upper_byte_we_in)
      inc_hold_nxt[ACC_W-1:16] = wr_data_in[ACC_W-17:0];

    acc_nxt = acc_r;
    carry_nxt = 1'b0;
    if (synth_edge)
    begin
      acc_nxt = sum[ACC_W-1:0];
      carry_nxt = sum[ACC_W];
    end
    if (accumulator_low_byte_we_in)
      acc_nxt[7:0] = wr_data_in;
    if (accumulator_high_byte_we_in)
      acc_nxt[15:8] = wr_data_in;
    if (accumulator_upper_byte_we_in)
      acc_nxt[ACC_W-1:16] = wr_data_in[ACC_W-17:0];
    if (!enable_in)
      carry_nxt = 1'b0;
    flag_nxt = carry_nxt;
    src_d_nxt = src_lvl;
  end

  // =====================================================
  // increment buffer load sequencer
  always_comb
  begin
    inc_buf_nxt = inc_buf_r;
    ld_st_nxt = ld_st_r;
    ld_cnt_nxt = ld_cnt_r;
    if (!enable_in)
    begin
      inc_buf_nxt = inc_hold_nxt;
      ld_st_nxt = PAO_LD_IDLE;
      ld_cnt_nxt = 2'h0;
    end
    else
    begin
      case (ld_st_r)
        PAO_LD_IDLE:
        begin
          if (increment_low_byte_we_in)
          begin
            ld_st_nxt = PAO_LD_WAIT;
            ld_cnt_nxt = 2'h0;
          end
        end
        PAO_LD_WAIT:
        begin
          if (synth_edge)
          begin
            ld_cnt_nxt = ld_cnt_r + 2'h1;
            if (ld_cnt_r + 2'h1 == `PAO_INC_LOAD_EDGES)
            begin
              inc_buf_nxt = inc_hold_r;
              ld_st_nxt = PAO_LD_IDLE;
            end
          end
          // a fresh low write restarts the wait, even on the load edge
          if (increment_low_byte_we_in)
          begin
            ld_st_nxt = PAO_LD_WAIT;
            ld_cnt_nxt = 2'h0;
          end
        end
        default:
        begin
          ld_st_nxt = PAO_LD_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // output stage
  pao_pulse_gen #(
    .WSEL_W(WSEL_W)
  ) u_pulse (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .clear_in(~enable_in),
    .advance_in(synth_edge),
    .start_in(sum[ACC_W]),
    .wsel_in(pulse_width_select_in),
    .active_out(pulse_act)
  );

  always_comb
  begin
    tog_nxt = tog_r;
    if (synth_edge && sum[ACC_W])
      tog_nxt = ~tog_r;
    if (!enable_in)
      tog_nxt = 1'b0;
    out_nxt = pulse_mode_select_in ? pulse_act : tog_r;
    if (!enable_in)
      out_nxt = 1'b0;
    pin_nxt = out_nxt ^ output_invert_in;
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      inc_hold_r <= `PAO_INC_RST;
      inc_buf_r <= `PAO_INC_RST;
      acc_r <= `PAO_ACC_RST;
      ld_st_r <= PAO_LD_IDLE;
      ld_cnt_r <= 2'h0;
      src_d_r <= 1'b0;
      carry_r <= 1'b0;
      flag_r <= 1'b0;
      tog_r <= 1'b0;
      out_r <= 1'b0;
      pin_r <= 1'b0;
    end
    else if (ce_in)
    begin
      inc_hold_r <= inc_hold_nxt;
      inc_buf_r <= inc_buf_nxt;
      acc_r <= acc_nxt;
      ld_st_r <= ld_st_nxt;
      ld_cnt_r <= ld_cnt_nxt;
      src_d_r <= src_d_nxt;
      carry_r <= carry_nxt;
      flag_r <= flag_nxt;
      tog_r <= tog_nxt;
      out_r <= out_nxt;
      pin_r <= pin_nxt;
    end
  end

  // =====================================================
  // outputs
  // only holding value visible
  assign increment_out = inc_hold_r;
  assign accumulator_out = acc_r;
  assign accumulator_carry_out = carry_r;
  assign overflow_flag_out = flag_r;
  assign out_status_out = out_r;

  assign synth_out = pin_r;

endmodule : pao_core

// >>> core/pao_cfg.svh
// Purpose: constants for the phase accumulator oscillator
// Assumes: included by bare name from the package only; the core files use its macros without including it
// Notes: codes follow the clock source and pulse width fields
`ifndef PAO_CFG_SVH
`define PAO_CFG_SVH

// =====================================================
// widths and reset values
`define PAO_ACC_W 20
`define PAO_ACC_RST 20'h00000
`define PAO_INC_RST 20'h00000
`define PAO_WSEL_W 3
`define PAO_CKS_W 4
`define PAO_CKS_SRC_N 11

// =====================================================
// timing: when enabled, increment buffer loads on second synth clock edge after low byte write; when disabled, it tracks the holding value
`define PAO_INC_LOAD_EDGES 2'h2

`endif

// >>> core/pao_pkg.sv
// Purpose: types for the phase accumulator oscillator
// Assumes: pao_cfg.svh sits beside this file
// Notes: constants live in the header, types here
`include "pao_cfg.svh"

package pao_pkg;

  typedef logic [`PAO_ACC_W-1:0] pao_word_t;

  // =====================================================
  // clock source codes
  typedef enum logic [`PAO_CKS_W-1:0] {
    PAO_CKS_SYS = 4'h0,
    PAO_CKS_HFI = 4'h1,
    PAO_CKS_LFI = 4'h2,
    PAO_CKS_MFI = 4'h3,
    PAO_CKS_MFI4 = 4'h4,
    PAO_CKS_SEC = 4'h5,
    PAO_CKS_REF = 4'h6,
    PAO_CKS_LC1 = 4'h7,
    PAO_CKS_LC2 = 4'h8,
    PAO_CKS_LC3 = 4'h9,
    PAO_CKS_LC4 = 4'hA
  } pao_cks_t;

  // =====================================================
  // increment load sequencer states
  typedef enum logic [1:0] {
    PAO_LD_IDLE = 2'b00,
    PAO_LD_WAIT = 2'b01
  } pao_ld_state_t;

endpackage : pao_pkg

// >>> core/pao_pulse_gen.sv
// Purpose: pulse width counter for pulse output mode
// Assumes: advance_in marks a synth clock edge in the mclk domain
// Notes: width code n gives 2^n synth clock periods
`timescale 1ns/100ps

module pao_pulse_gen
  import pao_pkg::*;
#(
  parameter int WSEL_W = `PAO_WSEL_W
)
(
  input wire logic mclk_in,             // module clock
  input wire logic rst_n_in,            // sync reset, active low
  input wire logic ce_in,               // clock enable
  input wire logic clear_in,            // force idle
  input wire logic advance_in,          // synth clock edge strobe
  input wire logic start_in,            // carry seen on this edge
  input wire logic [WSEL_W-1:0] wsel_in, // width code
  output logic active_out               // pulse active
);

  logic [7:0] cnt_r;
  logic [7:0] cnt_nxt;
  logic act_r;
  logic act_nxt;
  logic [7:0] width_m1;

  assign width_m1 = 8'((9'h001 << wsel_in) - 9'h001);
  assign active_out = act_r;

  always_comb
  begin
    cnt_nxt = cnt_r;
    act_nxt = act_r;
    if (clear_in)
    begin
      cnt_nxt = 8'h00;
      act_nxt = 1'b0;
    end
    else if (advance_in)
    begin
      // restart on carry, width undefined if longer than carry period
      if (start_in)
      begin
        cnt_nxt = width_m1;
        act_nxt = 1'b1;
      end
      else if (cnt_r != 8'h00)
      begin
        cnt_nxt = cnt_r - 8'h01;
      end
      else
      begin
        act_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (!rst_n_in)
    begin
      cnt_r <= 8'h00;
      act_r <= 1'b0;
    end
    else if (ce_in)
    begin
      cnt_r <= cnt_nxt;
      act_r <= act_nxt;
    end
  end

endmodule : pao_pulse_gen

// >>> testbench/pao_core_monitor.sv
// Purpose: port checker for pao_core
// Assumes: sources low during reset, checks paused while ce_in is low
// Notes: bound to the core after the module
`timescale 1ns/100ps

module pao_core_monitor
  import pao_pkg::*;
#(
  parameter int ACC_W = 20,
  parameter int SRC_N = 11
)
(
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic ce_in, // clock enable
  input wire logic enable_in, // enable
  input wire logic pulse_mode_select_in, // mode
  input wire logic output_invert_in, // polarity
  input wire logic [3:0] clock_source_select_in, // source code
  input wire logic [SRC_N-1:0] clk_src_in, // sources
  input wire logic accumulator_low_byte_we_in, // write
  input wire logic accumulator_high_byte_we_in, // write
  input wire logic accumulator_upper_byte_we_in, // write
  input wire logic [ACC_W-1:0] accumulator_out, // accumulator
  input wire logic accumulator_carry_out, // carry
  input wire logic overflow_flag_out, // flag
  input wire logic synth_out, // output
  input wire logic out_status_out // status
);
  wire logic sel_w = clock_source_select_in < 4'hB && clk_src_in[clock_source_select_in];
  // byte writes win over the sum, so they mask the adder checks
  wire logic aw_w = accumulator_low_byte_we_in | accumulator_high_byte_we_in
    | accumulator_upper_byte_we_in;

  default clocking @(posedge mclk_in);
  endclocking
  // frozen cycles break the edge history, so they pause the checks
  default disable iff (!rst_n_in || !ce_in);

  // =====
  // synth edge
  sequence edge_s;
    !sel_w ##1 (sel_w && enable_in && !aw_w);
  endsequence

  carry_wrap_a:
    assert property (edge_s |=> accumulator_carry_out
      == (accumulator_out < $past(accumulator_out))) else $error("carry mismatch");
  acc_hold_a:
    assert property (!aw_w && !(sel_w && !$past(sel_w) && enable_in)
      |=> $stable(accumulator_out)) else $error("accumulator moved");
  carry_single_a:
    assert property (accumulator_carry_out |=> !accumulator_carry_out) else $error("long carry");
  flag_pair_a:
    assert property (overflow_flag_out == accumulator_carry_out) else $error("flag mismatch");
  off_quiet_a:
    assert property (!enable_in |=> !accumulator_carry_out) else $error("carry when off");
  off_idle_a:
    assert property (!enable_in [*3] |=> !out_status_out) else $error("output active when off");
  polarity_a:
    assert property ($past(rst_n_in) && $stable(output_invert_in)
      |-> synth_out == (out_status_out ^ output_invert_in)) else $error("polarity wrong");
  toggle_a:
    assert property (accumulator_carry_out && enable_in && !pulse_mode_select_in
      |=> out_status_out != $past(out_status_out)) else $error("no toggle");
  pulse_on_a:
    assert property (accumulator_carry_out && enable_in && pulse_mode_select_in
      |=> out_status_out) else $error("no pulse");
endmodule : pao_core_monitor

bind pao_core pao_core_monitor #(.ACC_W(ACC_W), .SRC_N(SRC_N)) u_mon
(
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .ce_in(ce_in),
  .enable_in(enable_in),
  .pulse_mode_select_in(pulse_mode_select_in),
  .output_invert_in(output_invert_in),
  .clock_source_select_in(clock_source_select_in),
  .clk_src_in(clk_src_in),
  .accumulator_low_byte_we_in(accumulator_low_byte_we_in),
  .accumulator_high_byte_we_in(accumulator_high_byte_we_in),
  .accumulator_upper_byte_we_in(accumulator_upper_byte_we_in),
  .accumulator_out(accumulator_out),
  .accumulator_carry_out(accumulator_carry_out),
  .overflow_flag_out(overflow_flag_out),
  .synth_out(synth_out),
  .out_status_out(out_status_out)
);

// >>> testbench/pao_sink_model.sv
// Purpose: consumer of the synthesized output
// Assumes: shares mclk with the core
// Notes: width is the last high phase in mclk cycles
`timescale 1ns/100ps

module pao_sink_model
  import pao_pkg::*;
(
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic sig_in, // synth output
  output int width_out, // last high width
  output int rise_out // rising edges
);
  int run_r;
  logic prev_r;

  always @(posedge mclk_in)
  begin
    prev_r <= sig_in;
    run_r <= sig_in ? run_r + 1 : 0;
    if (!rst_n_in)
      rise_out <= 0;
    else if (sig_in && !prev_r)
      rise_out <= rise_out + 1;
    if (prev_r && !sig_in)
      width_out <= run_r;
  end
endmodule : pao_sink_model

// >>> testbench/testbench.sv
// Purpose: self-checking bench for pao_core
// Assumes: sources change on falling mclk edges
// Notes: a free running source has a two cycle period
`timescale 1ns/100ps

module testbench
  import pao_pkg::*;
;
  logic mclk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic en = 1'b0;
  logic ce = 1'b1;
  logic pm = 1'b0;
  logic inv = 1'b0;
  logic [2:0] wsel = 3'h0;
  logic [3:0] cks = 4'h0;
  logic [10:0] src;
  logic [10:0] man = 11'h000;
  logic [10:0] tog = 11'h000;
  logic [7:0] wd = 8'h00;
  logic [5:0] we = 6'h00;
  logic run = 1'b0;
  logic c;
  logic f;
  logic fl;
  logic cy;
  logic st;
  logic so;
  logic [19:0] m;
  logic [19:0] inc_o;
  logic [19:0] acc_o;
  int width;
  int rises;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;

  pao_core dut
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce),
    .enable_in(en),
    .pulse_mode_select_in(pm),
    .output_invert_in(inv),
    .pulse_width_select_in(wsel),
    .clock_source_select_in(cks),
    .clk_src_in(src),
    .wr_data_in(wd),
    .increment_low_byte_we_in(we[0]),
    .increment_high_byte_we_in(we[1]),
    .increment_upper_byte_we_in(we[2]),
    .accumulator_low_byte_we_in(we[3]),
    .accumulator_high_byte_we_in(we[4]),
    .accumulator_upper_byte_we_in(we[5]),
    .increment_out(inc_o),
    .accumulator_out(acc_o),
    .accumulator_carry_out(cy),
    .overflow_flag_out(fl),
    .synth_out(so),
    .out_status_out(st)
  );

  pao_sink_model sink
  (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .sig_in(so),
    .width_out(width),
    .rise_out(rises)
  );

  initial
  begin
    forever #12.5 mclk_in = ~mclk_in;
  end

  // one driver for the sources: free run or the step pattern
  always @(negedge mclk_in)
  begin
    if (run)
      tog <= tog ^ (11'h001 << cks);
    else
      tog <= 11'h000;
  end

  assign src = run ? tog : man;

  // =====
  // hang guard
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_errors++;
      give_verdict();
    end
  end

  task check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task wr(input int i, input logic [7:0] d);
    @(negedge mclk_in);
    wd = d;
    we = 6'h01 << i;
    @(negedge mclk_in);
    we = 6'h00;
  endtask : wr

  // low byte last so the buffer load starts after the whole word
  task put(input int b, input logic [19:0] v);
    wr(b + 2, {4'h0, v[19:16]});
    wr(b + 1, v[15:8]);
    wr(b, v[7:0]);
  endtask : put

  // carry is caught on either of the two cycles after the rise
  task step(input logic [10:0] mk, input logic [19:0] ea, input logic ec);
    @(negedge mclk_in);
    man = mk;
    @(negedge mclk_in);
    man = 11'h000;
    c = cy;
    f = fl;
    @(negedge mclk_in);
    c = c | cy;
    f = f | fl;
    check(acc_o, ea);
    check(c, ec);
    check(f, ec);
  endtask : step

  task waitr;
    int r0;
    r0 = rises;
    repeat (2000)
      if (rises < r0 + 2)
        @(negedge mclk_in);
  endtask : waitr

  task give_verdict;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : give_verdict

  initial
  begin
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1'b1;
    check(acc_o, 20'h00000);
    put(0, 20'h01234);
    check(inc_o, 20'h01234);
    put(3, 20'hFFF00);
    check(acc_o, 20'hFFF00);
    step(11'h001, 20'hFFF00, 1'b0);
    en = 1'b1;
    step(11'h001, 20'h01134, 1'b1);
    step(11'h001, 20'h02368, 1'b0);
    $display("test accumulate done");
    put(0, 20'h00010);
    step(11'h001, 20'h0359C, 1'b0);
    step(11'h001, 20'h047D0, 1'b0);
    step(11'h001, 20'h047E0, 1'b0);
    ce = 1'b0;
    step(11'h001, 20'h047E0, 1'b0);
    ce = 1'b1;
    $display("test buffer done");
    m = 20'h047E0;
    for (int k = 0; k < 11; k++)
    begin
      cks = k[3:0];
      step(11'h7FF ^ (11'h001 << k), m, 1'b0);
      m = m + 20'h00010;
      step(11'h001 << k, m, 1'b0);
    end
    cks = 4'hB;
    step(11'h7FF, m, 1'b0);
    $display("test sources done");
    en = 1'b0;
    put(0, 20'h40000);
    cks = 4'h0;
    en = 1'b1;
    run = 1'b1;
    waitr();
    check(width, 8);
    $display("test toggle done");
    pm = 1'b1;
    put(0, 20'h01000);
    for (int p = 0; p < 8; p++)
    begin
      wsel = p[2:0];
      waitr();
      check(width, 2 << p);
    end
    $display("test pulse done");
    run = 1'b0;
    en = 1'b0;
    inv = 1'b1;
    repeat (4) @(negedge mclk_in);
    check(st, 1'b0);
    check(so, 1'b1);
    $display("test polarity done");
    give_verdict();
  end
endmodule : testbench
